// [hdl/dtss_pkg.sv]
package dtss_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CONV_PERIOD_MS = 125;
  localparam int CONV_CYCLES = CONV_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TOUT_MS = 25;
  localparam int TOUT_CYCLES = TOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // slave address
  localparam logic [3:0] ADDR_FIXED = 4'h3;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

  // register pointers
  localparam logic [7:0] PTR_CONFIG = 8'h01;
  localparam logic [7:0] PTR_UPPER = 8'h02;
  localparam logic [7:0] PTR_LOWER = 8'h03;
  localparam logic [7:0] PTR_CRIT = 8'h04;
  localparam logic [7:0] PTR_TEMP = 8'h05;
  localparam logic [7:0] PTR_MFR_ID = 8'h06;
  localparam logic [7:0] PTR_DEV_ID = 8'h07;

  // configuration fields
  localparam int CFG_MODE_INT = 0;
  localparam int CFG_POL_HIGH = 1;
  localparam int CFG_CRIT_ONLY = 2;
  localparam int CFG_EVT_EN = 3;
  localparam int CFG_EVT_STAT = 4;
  localparam int CFG_EVT_CLR = 5;
  localparam int CFG_WIN_LOCK = 6;
  localparam int CFG_CRIT_LOCK = 7;
  localparam int CFG_SHDN = 8;
  localparam int CFG_HYS_LO = 9;
  localparam int CFG_TOUT_DIS = 11;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] LIMIT_RESET = 16'h0000;

  // temperature word layout: value in bits 12..2, flags above
  localparam int TEMP_W = 11;
  localparam int TEMP_LSB = 2;
  localparam int TEMP_MSB = 12;
  localparam int FLAG_CRIT = 15;
  localparam int FLAG_ABOVE = 14;
  localparam int FLAG_BELOW = 13;

  // hysteresis in eighths of a degree
  localparam logic [11:0] HYS_0 = 12'h000;
  localparam logic [11:0] HYS_1P5 = 12'h00C;
  localparam logic [11:0] HYS_3 = 12'h018;
  localparam logic [11:0] HYS_6 = 12'h030;

  // serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_MACK = 3'b101
  } dtss_state_t;
endpackage : dtss_pkg

// [hdl/dtss_sync.sv]
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for pins from outside the clock domain
module dtss_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule : dtss_sync
`default_nettype wire

// [hdl/dtss_top.sv]
`timescale 1ns/1ns
`default_nettype none
module dtss_top #(
  parameter int CONV_CYCLES = dtss_pkg::CONV_CYCLES,
  parameter int TOUT_CYCLES = dtss_pkg::TOUT_CYCLES,
  parameter logic [15:0] MFR_ID = 16'h1234, // arbitrary value
  parameter logic [15:0] DEV_ID = 16'h5678 // arbitrary value
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // two-wire bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // address select pins
  input wire logic i_addr_select_bit_zero,
  input wire logic i_addr_select_bit_one,
  input wire logic i_addr_select_bit_two,
  // thermal sensing core
  input wire logic [dtss_pkg::TEMP_W-1:0] i_thermal_sensing_core_temp,
  output logic o_conv_tick,
  output logic o_shutdown,
  // alarm pin
  output logic o_event_o,
  output logic o_event_oe
);
  // refuse counts that the counters cannot serve
  if (CONV_CYCLES < 2 || TOUT_CYCLES < 2) begin : g_bad_counts
    $error("dtss_top: counts too small");
  end

  // synchronised pins
  logic [4:0] pins_s;
  logic scl_s, sda_s, scl_d_r, sda_d_r;
  logic [2:0] pin_addr_s;

  dtss_sync #(.W(5)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_scl, i_sda, i_addr_select_bit_two, i_addr_select_bit_one,
              i_addr_select_bit_zero}),
    .o_sync(pins_s)
  );
  assign scl_s = pins_s[4];
  assign sda_s = pins_s[3];
  assign pin_addr_s = pins_s[2:0];

  // edge and condition detection on the bus
  logic scl_rise, scl_fall, start_cond, stop_cond;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // registers reached over the bus
  logic [15:0] cfg_r, upper_r, lower_r, crit_r, temp_word;
  logic [7:0] ptr_r;
  logic [10:0] temp_r;
  logic above_r, below_r, crit_flag_r, irq_r, asserted;
  logic wr_stb, clr_evt, ara_clr;
  logic [7:0] wr_msb_r, shift_r;
  logic [15:0] rd_word;

  // conversion tick, eight per second
  logic [31:0] conv_cnt_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      conv_cnt_r <= '0;
      o_conv_tick <= 1'b0;
    end else if (conv_cnt_r == 32'(CONV_CYCLES - 1)) begin
      conv_cnt_r <= '0;
      o_conv_tick <= ~cfg_r[dtss_pkg::CFG_SHDN];
    end else begin
      conv_cnt_r <= conv_cnt_r + 32'h0000_0001;
      o_conv_tick <= 1'b0;
    end
  end

  // latch each new result, frozen in shutdown
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      temp_r <= '0;
      o_shutdown <= 1'b0;
    end else begin
      o_shutdown <= cfg_r[dtss_pkg::CFG_SHDN];
      if (o_conv_tick) begin
        temp_r <= i_thermal_sensing_core_temp;
      end
    end
  end

  // threshold comparisons with hysteresis
  logic [11:0] hys, t12, up12, lo12, cr12;
  always_comb begin
    unique case (cfg_r[dtss_pkg::CFG_HYS_LO +: 2])
      2'b00: hys = dtss_pkg::HYS_0;
      2'b01: hys = dtss_pkg::HYS_1P5;
      2'b10: hys = dtss_pkg::HYS_3;
      2'b11: hys = dtss_pkg::HYS_6;
    endcase
  end
  assign t12 = {temp_r[10], temp_r};
  assign up12 = {upper_r[dtss_pkg::TEMP_MSB], upper_r[dtss_pkg::TEMP_MSB:dtss_pkg::TEMP_LSB]};
  assign lo12 = {lower_r[dtss_pkg::TEMP_MSB], lower_r[dtss_pkg::TEMP_MSB:dtss_pkg::TEMP_LSB]};
  assign cr12 = {crit_r[dtss_pkg::TEMP_MSB], crit_r[dtss_pkg::TEMP_MSB:dtss_pkg::TEMP_LSB]};

  // window and critical flags
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      above_r <= 1'b0;
      below_r <= 1'b0;
      crit_flag_r <= 1'b0;
    end else begin
      above_r <= above_r ? ($signed(t12) > $signed(up12 - hys))
                         : ($signed(t12) > $signed(up12));
      below_r <= below_r ? ($signed(t12) < $signed(lo12 + hys))
                         : ($signed(t12) < $signed(lo12));
      crit_flag_r <= crit_flag_r ? ($signed(t12) >= $signed(cr12 - hys))
                                 : ($signed(t12) >= $signed(cr12));
    end
  end

  // latched interrupt: window crossings set it, clear or alert response
  logic above_d_r, below_d_r;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      irq_r <= 1'b0;
      above_d_r <= 1'b0;
      below_d_r <= 1'b0;
    end else begin
      above_d_r <= above_r;
      below_d_r <= below_r;
      if ((above_r ^ above_d_r) | (below_r ^ below_d_r)) begin
        irq_r <= 1'b1; // set wins over clear
      end else if (clr_evt | ara_clr) begin
        irq_r <= 1'b0;
      end
    end
  end

  // critical forces comparator behaviour
  always_comb begin
    if (cfg_r[dtss_pkg::CFG_CRIT_ONLY]) begin
      asserted = crit_flag_r;
    end else if (cfg_r[dtss_pkg::CFG_MODE_INT]) begin
      asserted = crit_flag_r | irq_r;
    end else begin
      asserted = crit_flag_r | above_r | below_r;
    end
  end

  // open-drain alarm pin; released while disabled
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_event_o <= 1'b0;
      o_event_oe <= 1'b0;
    end else begin
      o_event_o <= 1'b0;
      o_event_oe <= cfg_r[dtss_pkg::CFG_EVT_EN]
                    & (asserted ^ cfg_r[dtss_pkg::CFG_POL_HIGH]);
    end
  end

  // read mux
  assign temp_word = {crit_flag_r, above_r, below_r, temp_r, 2'b00};
  always_comb begin
    unique case (ptr_r)
      dtss_pkg::PTR_CONFIG: begin
        rd_word = cfg_r;
        rd_word[dtss_pkg::CFG_EVT_STAT] = asserted;
      end
      dtss_pkg::PTR_UPPER: rd_word = upper_r;
      dtss_pkg::PTR_LOWER: rd_word = lower_r;
      dtss_pkg::PTR_CRIT: rd_word = crit_r;
      dtss_pkg::PTR_TEMP: rd_word = temp_word;
      dtss_pkg::PTR_MFR_ID: rd_word = MFR_ID;
      dtss_pkg::PTR_DEV_ID: rd_word = DEV_ID;
      default: rd_word = 16'h0000;
    endcase
  end

  // register writes; locks and enable guard
  logic [15:0] wdata;
  assign wdata = {wr_msb_r, shift_r};
  assign clr_evt = wr_stb & (ptr_r == dtss_pkg::PTR_CONFIG) & wdata[dtss_pkg::CFG_EVT_CLR];
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cfg_r <= dtss_pkg::CFG_RESET;
      upper_r <= dtss_pkg::LIMIT_RESET;
      lower_r <= dtss_pkg::LIMIT_RESET;
      crit_r <= dtss_pkg::LIMIT_RESET;
    end else if (wr_stb) begin
      unique case (ptr_r)
        dtss_pkg::PTR_CONFIG: begin
          cfg_r <= wdata;
          cfg_r[dtss_pkg::CFG_EVT_STAT] <= 1'b0;
          cfg_r[dtss_pkg::CFG_EVT_CLR] <= 1'b0;
          cfg_r[dtss_pkg::CFG_WIN_LOCK] <= cfg_r[dtss_pkg::CFG_WIN_LOCK]
                                           | wdata[dtss_pkg::CFG_WIN_LOCK];
          cfg_r[dtss_pkg::CFG_CRIT_LOCK] <= cfg_r[dtss_pkg::CFG_CRIT_LOCK]
                                            | wdata[dtss_pkg::CFG_CRIT_LOCK];
          if (cfg_r[dtss_pkg::CFG_EVT_EN] & wdata[dtss_pkg::CFG_EVT_EN]) begin
            cfg_r[dtss_pkg::CFG_MODE_INT] <= cfg_r[dtss_pkg::CFG_MODE_INT];
            cfg_r[dtss_pkg::CFG_CRIT_ONLY] <= cfg_r[dtss_pkg::CFG_CRIT_ONLY];
          end
        end
        dtss_pkg::PTR_UPPER: begin
          if (!cfg_r[dtss_pkg::CFG_WIN_LOCK]) upper_r <= wdata;
        end
        dtss_pkg::PTR_LOWER: begin
          if (!cfg_r[dtss_pkg::CFG_WIN_LOCK]) lower_r <= wdata;
        end
        dtss_pkg::PTR_CRIT: begin
          if (!cfg_r[dtss_pkg::CFG_CRIT_LOCK]) crit_r <= wdata;
        end
        default: ;
      endcase
    end
  end

  // serial slave state machine
  dtss_pkg::dtss_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] byte_cnt_r;
  logic [2:0] addr_pins_r;
  logic rw_r, ara_r, byte_hi_r, mack_r, sda_drv_r;
  logic [31:0] tout_cnt_r;
  logic timeout;

  // bus timeout while clock is held low mid-transfer
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tout_cnt_r <= '0;
    end else if (scl_s || state_r == dtss_pkg::ST_IDLE) begin
      tout_cnt_r <= '0;
    end else if (!timeout) begin
      tout_cnt_r <= tout_cnt_r + 32'h0000_0001;
    end
  end
  assign timeout = ~cfg_r[dtss_pkg::CFG_TOUT_DIS]
                   & (tout_cnt_r == 32'(TOUT_CYCLES - 1));

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_r <= dtss_pkg::ST_IDLE;
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
      shift_r <= '0;
      wr_msb_r <= '0;
      ptr_r <= '0;
      addr_pins_r <= '0;
      rw_r <= 1'b0;
      ara_r <= 1'b0;
      byte_hi_r <= 1'b0;
      mack_r <= 1'b0;
      sda_drv_r <= 1'b0;
      wr_stb <= 1'b0;
      ara_clr <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      ara_clr <= 1'b0;
      if (timeout || stop_cond) begin
        state_r <= dtss_pkg::ST_IDLE;
        sda_drv_r <= 1'b0;
      end else if (start_cond) begin
        state_r <= dtss_pkg::ST_ADDR;
        bit_cnt_r <= '0;
        sda_drv_r <= 1'b0;
        addr_pins_r <= pin_addr_s;
      end else begin
        unique case (state_r)
          dtss_pkg::ST_IDLE: sda_drv_r <= 1'b0;
          dtss_pkg::ST_ADDR, dtss_pkg::ST_RX: begin
            if (scl_rise && bit_cnt_r < 4'h8) begin
              shift_r <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              if (state_r == dtss_pkg::ST_ADDR) begin
                if (shift_r[7:1] == {dtss_pkg::ADDR_FIXED, addr_pins_r}) begin
                  sda_drv_r <= 1'b1;
                  state_r <= dtss_pkg::ST_ACK;
                  rw_r <= shift_r[0];
                  ara_r <= 1'b0;
                  byte_cnt_r <= '0;
                  byte_hi_r <= 1'b1;
                end else if (shift_r == {dtss_pkg::ALERT_RESP_ADDR, 1'b1}
                             && asserted && !crit_flag_r) begin
                  sda_drv_r <= 1'b1;
                  state_r <= dtss_pkg::ST_ACK;
                  rw_r <= 1'b1;
                  ara_r <= 1'b1;
                end else begin
                  state_r <= dtss_pkg::ST_IDLE;
                end
              end else begin
                sda_drv_r <= 1'b1;
                state_r <= dtss_pkg::ST_ACK;
                if (byte_cnt_r == 2'd0) begin
                  ptr_r <= shift_r;
                  byte_cnt_r <= 2'd1;
                end else if (byte_cnt_r == 2'd1) begin
                  wr_msb_r <= shift_r;
                  byte_cnt_r <= 2'd2;
                end else begin
                  wr_stb <= 1'b1;
                  byte_cnt_r <= 2'd1;
                end
              end
            end
          end
          dtss_pkg::ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= '0;
              if (rw_r) begin
                state_r <= dtss_pkg::ST_TX;
                if (ara_r) begin
                  shift_r <= {dtss_pkg::ADDR_FIXED, addr_pins_r, 1'b0};
                  sda_drv_r <= ~dtss_pkg::ADDR_FIXED[3];
                  ara_clr <= 1'b1;
                end else begin
                  shift_r <= rd_word[15:8];
                  sda_drv_r <= ~rd_word[15];
                  byte_hi_r <= 1'b0;
                end
              end else begin
                state_r <= dtss_pkg::ST_RX;
                sda_drv_r <= 1'b0;
              end
            end
          end
          dtss_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h7) begin
                sda_drv_r <= 1'b0;
                state_r <= dtss_pkg::ST_MACK;
              end else begin
                shift_r <= {shift_r[6:0], 1'b0};
                sda_drv_r <= ~shift_r[6];
                bit_cnt_r <= bit_cnt_r + 4'h1;
              end
            end
          end
          dtss_pkg::ST_MACK: begin
            if (scl_rise) begin
              mack_r <= ~sda_s;
            end else if (scl_fall) begin
              if (mack_r && !ara_r) begin
                state_r <= dtss_pkg::ST_TX;
                bit_cnt_r <= '0;
                shift_r <= byte_hi_r ? rd_word[15:8] : rd_word[7:0];
                sda_drv_r <= byte_hi_r ? ~rd_word[15] : ~rd_word[7];
                byte_hi_r <= ~byte_hi_r;
              end else begin
                state_r <= dtss_pkg::ST_IDLE;
              end
            end
          end
          default: state_r <= dtss_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // data pin: pull low or release only
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_sda_o <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_sda_o <= 1'b0;
      o_sda_oe <= sda_drv_r;
    end
  end
endmodule : dtss_top
`default_nettype wire

// [tb/dtss_chk.sv]
`timescale 1ns/1ns
`default_nettype none
// port-level checks on the sensor slave
module dtss_chk #(
  parameter int CONV_CYCLES = 200,
  parameter int TOUT_CYCLES = 300
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // bus pins
  input wire logic i_scl,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  // conversion and alarm
  input wire logic o_conv_tick,
  input wire logic o_shutdown,
  input wire logic o_event_o,
  input wire logic o_event_oe
);
  int gap_r;
  int low_r;
  logic seen_r;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // cycles since the last conversion tick
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || o_conv_tick) gap_r <= 0;
    else gap_r <= gap_r + 1;
  end
  // a tick seen since reset or shutdown
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || o_shutdown) seen_r <= 1'b0;
    else if (o_conv_tick) seen_r <= 1'b1;
  end
  // length of the current clock low phase, saturating
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || i_scl) low_r <= 0;
    else if (low_r < TOUT_CYCLES + 100) low_r <= low_r + 1;
  end
  sequence s_tick_quiet;
    (!o_conv_tick) [*8];
  endsequence
  property p_tick_pulse;
    o_conv_tick |=> s_tick_quiet;
  endproperty
  sda_pull_only_a: assert property (o_sda_o == 1'b0)
    else $error("data pin driven high");
  event_pull_only_a: assert property (o_event_o == 1'b0)
    else $error("alarm pin driven high");
  reset_release_a: assert property ($rose(i_rst_n) |-> !o_event_oe && !o_sda_oe)
    else $error("pins not released after reset");
  tick_pulse_a: assert property (p_tick_pulse)
    else $error("conversion tick too long");
  tick_period_a: assert property (o_conv_tick && seen_r |-> gap_r == CONV_CYCLES - 1)
    else $error("conversion period wrong");
  shutdown_quiet_a: assert property (o_shutdown && $past(o_shutdown) |-> !o_conv_tick)
    else $error("conversion during shutdown");
  sda_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data changed while clock high");
  timeout_free_a: assert property (low_r >= TOUT_CYCLES + 8 |-> !o_sda_oe)
    else $error("data held past timeout");
  cover property (o_conv_tick && seen_r);
endmodule : dtss_chk
bind dtss_top dtss_chk #(.CONV_CYCLES(CONV_CYCLES), .TOUT_CYCLES(TOUT_CYCLES)) dtss_chk_inst (
  .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_conv_tick(o_conv_tick), .o_shutdown(o_shutdown),
  .o_event_o(o_event_o), .o_event_oe(o_event_oe));
`default_nettype wire

// [tb/dtss_master.sv]
`timescale 1ns/1ns
`default_nettype none
// bus master model, data line open drain, clock line driven high and low
module dtss_master (
  // clock
  input wire logic i_ref_clk,
  // bus lines
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  logic in_frame = 1'b0;
  // lines released, clock still between frames
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // wait whole reference clocks
  task automatic w(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : w
  // clock held low, also used to stall
  task automatic stall(input int n);
    w(1);
    o_scl <= 1'b0;
    w(n);
  endtask : stall
  // one bit of 160 ns: data set in low phase, read at end of high
  task automatic bit_x(input logic b, output logic r);
    stall(4);
    o_sda_low <= !b;
    w(4);
    o_scl <= 1'b1;
    w(7);
    r = i_sda;
  endtask : bit_x
  // start, or repeated start inside a frame
  task automatic start();
    if (in_frame) begin
      stall(4);
      o_sda_low <= 1'b0;
      w(4);
      o_scl <= 1'b1;
    end
    w(8);
    o_sda_low <= 1'b1;
    w(8);
    in_frame = 1'b1;
  endtask : start
  // stop, lines left released
  task automatic stop();
    stall(4);
    o_sda_low <= 1'b1;
    w(4);
    o_scl <= 1'b1;
    w(8);
    o_sda_low <= 1'b0;
    w(8);
    in_frame = 1'b0;
  endtask : stop
  // byte out msb first, then the acknowledge bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], ack);
    bit_x(1'b1, ack);
  endtask : wbyte
  // byte in msb first, then acknowledge or not
  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nack, r);
  endtask : rbyte
endmodule : dtss_master
`default_nettype wire

// [tb/dtss_top_test.sv]
`timescale 1ns/1ns
`default_nettype none
// self-checking bench for the sensor slave
module dtss_top_test;
  localparam int CONV = 200;
  localparam int TOUT = 300;
  localparam logic [15:0] MFR = 16'h1234; // arbitrary value
  localparam logic [15:0] DEV = 16'h5678; // arbitrary value
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [2:0] pins = 3'h0;
  logic [10:0] temp = 11'h000;
  logic [16:0] lf = 17'h10C41;
  logic sda, scl, sda_low, sda_o, sda_oe, tick, shdn, ev_o, ev_oe, a;
  logic [15:0] v;
  logic [7:0] ab;
  int mismatches = 0;
  int cmp_count = 0;
  int k;
  int hv [4] = '{0, 12, 24, 48};
  logic [15:0] cfgs [7] = '{16'h0008, 16'h0008, 16'h000A, 16'h000A, 16'h0009, 16'h000C, 16'h000C};
  int tt [7] = '{240, 120, 120, 240, 120, 240, 720};
  logic ee [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  // 100 MHz reference clock
  always #5 i_ref_clk = ~i_ref_clk;
  // data line with pull-up
  assign sda = !(sda_low || sda_oe);
  dtss_top #(.CONV_CYCLES(CONV), .TOUT_CYCLES(TOUT), .MFR_ID(MFR), .DEV_ID(DEV)) dtss_top_inst (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_addr_select_bit_zero(pins[0]), .i_addr_select_bit_one(pins[1]),
    .i_addr_select_bit_two(pins[2]), .i_thermal_sensing_core_temp(temp),
    .o_conv_tick(tick), .o_shutdown(shdn), .o_event_o(ev_o), .o_event_oe(ev_oe));
  dtss_master dtss_master_inst (.i_ref_clk(i_ref_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_low(sda_low));
  // next random value
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction : lfsr
  // expected slave address from the strap pins
  function automatic logic [6:0] addr(input logic [2:0] p);
    return {dtss_pkg::ADDR_FIXED, p};
  endfunction : addr
  // limit word from eighths of a degree
  function automatic logic [15:0] lim(input int e);
    return 16'(e << 2);
  endfunction : lim
  // compare and count
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // register write through the bus
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    logic x;
    dtss_master_inst.start();
    dtss_master_inst.wbyte({addr(pins), 1'b0}, x);
    dtss_master_inst.wbyte(p, x);
    dtss_master_inst.wbyte(d[15:8], x);
    dtss_master_inst.wbyte(d[7:0], x);
    dtss_master_inst.stop();
  endtask : wr
  // register read, pointer then repeated start
  task automatic rd(input logic [6:0] ad, input logic [7:0] p, output logic [15:0] d,
                    output logic ack);
    logic x;
    d = 16'hFFFF;
    dtss_master_inst.start();
    dtss_master_inst.wbyte({ad, 1'b0}, ack);
    if (ack === 1'b0) begin
      dtss_master_inst.wbyte(p, x);
      dtss_master_inst.start();
      dtss_master_inst.wbyte({ad, 1'b1}, x);
      dtss_master_inst.rbyte(1'b0, d[15:8]);
      dtss_master_inst.rbyte(1'b1, d[7:0]);
    end
    dtss_master_inst.stop();
  endtask : rd
  // bounded wait for a conversion tick, then let flags settle
  task automatic wait_tick();
    int n;
    n = 0;
    do begin
      @(negedge i_ref_clk);
      n++;
    end while (tick !== 1'b1 && n < 1000);
    chk("tick", {15'h0, tick}, 16'h0001);
    repeat (4) @(negedge i_ref_clk);
  endtask : wait_tick
  // new core temperature, latched by two ticks
  task automatic settemp(input logic [10:0] t);
    @(posedge i_ref_clk);
    temp <= t;
    wait_tick();
    wait_tick();
  endtask : settemp
  // counts and verdict
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  // main sequence
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    @(negedge i_ref_clk);
    chk("alarm oe", {15'h0, ev_oe}, 16'h0000);
    repeat (4) @(posedge i_ref_clk);
    rd(addr(3'h0), dtss_pkg::PTR_MFR_ID, v, a);
    chk("maker id", v, MFR);
    wr(dtss_pkg::PTR_MFR_ID, 16'hFFFF);
    rd(addr(pins), dtss_pkg::PTR_MFR_ID, v, a);
    chk("maker id kept", v, MFR);
    $display("test identity done");
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      @(posedge i_ref_clk);
      pins <= lf[2:0];
      rd(addr(lf[2:0]), dtss_pkg::PTR_DEV_ID, v, a);
      chk("ack", {15'h0, a}, 16'h0000);
      chk("device id", v, DEV);
      rd(addr(~lf[2:0]), dtss_pkg::PTR_DEV_ID, v, a);
      chk("nack", {15'h0, a}, 16'h0001);
    end
    $display("test address done");
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      settemp(lf[10:0]);
      rd(addr(pins), dtss_pkg::PTR_TEMP, v, a);
      chk("temp", {3'h0, v[12:0]}, {3'h0, lf[10:0], 2'b00});
    end
    $display("test temperature done");
    wr(dtss_pkg::PTR_UPPER, lim(160));
    wr(dtss_pkg::PTR_LOWER, lim(80));
    wr(dtss_pkg::PTR_CRIT, lim(640));
    for (int i = 0; i < 7; i++) begin
      wr(dtss_pkg::PTR_CONFIG, 16'h0000);
      wr(dtss_pkg::PTR_CONFIG, cfgs[i]);
      settemp(11'(tt[i]));
      chk("alarm", {15'h0, ev_oe}, {15'h0, ee[i]});
      if (cfgs[i][0]) begin
        wr(dtss_pkg::PTR_CONFIG, 16'h0029);
        repeat (4) @(negedge i_ref_clk);
        chk("alarm cleared", {15'h0, ev_oe}, 16'h0000);
        settemp(11'd240);
        chk("alarm again", {15'h0, ev_oe}, 16'h0001);
        dtss_master_inst.start();
        dtss_master_inst.wbyte({dtss_pkg::ALERT_RESP_ADDR, 1'b1}, a);
        chk("alert ack", {15'h0, a}, 16'h0000);
        dtss_master_inst.rbyte(1'b1, ab);
        chk("alert addr", {8'h00, ab}, {8'h00, addr(pins), 1'b0});
        dtss_master_inst.stop();
        repeat (4) @(negedge i_ref_clk);
        chk("alert cleared", {15'h0, ev_oe}, 16'h0000);
      end
    end
    $display("test alarm done");
    for (int h = 0; h < 4; h++) begin
      wr(dtss_pkg::PTR_CONFIG, 16'h0000);
      wr(dtss_pkg::PTR_CONFIG, {5'h00, 2'(h), 9'h008});
      settemp(11'd240);
      chk("hys above", {15'h0, ev_oe}, 16'h0001);
      settemp(11'(161 - hv[h]));
      chk("hys held", {15'h0, ev_oe}, 16'h0001);
      settemp(11'(160 - hv[h]));
      chk("hys freed", {15'h0, ev_oe}, 16'h0000);
    end
    $display("test hysteresis done");
    wr(dtss_pkg::PTR_CONFIG, 16'h0100);
    @(negedge i_ref_clk);
    chk("shutdown", {15'h0, shdn}, 16'h0001);
    k = 0;
    repeat (450) begin
      @(negedge i_ref_clk);
      k += int'(tick === 1'b1);
    end
    chk("ticks", 16'(k), 16'h0000);
    wr(dtss_pkg::PTR_CONFIG, 16'h0000);
    wait_tick();
    chk("awake", {15'h0, shdn}, 16'h0000);
    $display("test shutdown done");
    wr(dtss_pkg::PTR_CONFIG, 16'h0040);
    wr(dtss_pkg::PTR_UPPER, 16'h0000);
    rd(addr(pins), dtss_pkg::PTR_UPPER, v, a);
    chk("upper locked", v, lim(160));
    ab = {addr(pins), 1'b0};
    dtss_master_inst.start();
    for (int i = 7; i >= 0; i--) dtss_master_inst.bit_x(ab[i], a);
    dtss_master_inst.stall(12);
    @(negedge i_ref_clk);
    chk("ack held", {15'h0, sda_oe}, 16'h0001);
    dtss_master_inst.stall(TOUT + 20);
    @(negedge i_ref_clk);
    chk("timeout", {15'h0, sda_oe}, 16'h0000);
    dtss_master_inst.stop();
    rd(addr(pins), dtss_pkg::PTR_DEV_ID, v, a);
    chk("after timeout", v, DEV);
    $display("test timeout done");
    results();
  end
  // watchdog on a hung run
  initial begin
    #900000;
    mismatches++;
    results();
  end
endmodule : dtss_top_test
`default_nettype wire
